// ---- include/adcs_params.svh ----
// constants for the converter control sequencer
// assumes inclusion by bare name from include/
`ifndef ADCS_PARAMS_SVH
`define ADCS_PARAMS_SVH
`define ADCS_ADDR_RES_HIGH 2'h0
`define ADCS_ADDR_RES_LOW 2'h1
`define ADCS_ADDR_CTRL 2'h2
`define ADCS_ADDR_SEL 2'h3
`define ADCS_CTRL_RESET 8'h00
`define ADCS_SEL_RESET 8'h00
`define ADCS_BIT_START 7
`define ADCS_BIT_BUSY 6
`define ADCS_BIT_EN 5
`define ADCS_BIT_ALIGN 4
`define ADCS_SAMPLE_PERIODS 5'h04
`define ADCS_TOTAL_PERIODS 5'h10
`define ADCS_SRC_BANDGAP 3'h1
`define ADCS_SRC_GND_LO 3'h2
`define ADCS_SRC_GND_HI 3'h4
`define ADCS_REF_SUPPLY 2'h1
`define ADCS_CHAN_COUNT 8
`endif

// ---- include/adcs_pkg.sv ----
// types shared by the converter control sequencer
// assumes nothing beyond a SystemVerilog compiler
package adcs_pkg;
	typedef enum logic [1:0] {
		ADCS_SRC_EXT,
		ADCS_SRC_BG,
		ADCS_SRC_GND
	} adcs_src_t;
	typedef enum logic [1:0] {
		ADCS_IDLE,
		ADCS_SAMPLE,
		ADCS_CONVERT
	} adcs_state_t;
endpackage

// ---- include/adcs_tick_if.sv ----
// carries the conversion clock tick between divider and sequencer
// assumes a single clock domain
`timescale 1ns/1ps
interface adcs_tick_if;
	logic [2:0] divider;
	logic run;
	logic tick;
	modport src (input divider, input run, output tick);
	modport dst (output divider, output run, input tick);
endinterface

// ---- core/adcs_clkdiv.sv ----
// conversion clock divider: one-cycle tick every 2^code system clocks, every 2 for code 0
// assumes a synchronous active-low reset already released cleanly
`timescale 1ns/1ps
module adcs_clkdiv #(
	parameter int DIV_W = 7
) (
	input wire logic clk,
	input wire logic rst_sync_b,
	adcs_tick_if.src tk
);
	import adcs_pkg::*;
	initial begin
		if (DIV_W < 7) $error("divider too narrow");
	end
	logic [DIV_W-1:0] cnt_reg;
	logic [DIV_W-1:0] mask;
	// code 000 reserved; treated as /2 so the sequencer never hangs
	assign mask = (tk.divider == 3'h0) ? DIV_W'(1) :
		DIV_W'((8'h01 << tk.divider) - 8'h01);
	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			cnt_reg <= '0;
		end else if (!tk.run) begin
			cnt_reg <= '0;
		end else begin
			cnt_reg <= (cnt_reg & mask) == mask ? '0 : cnt_reg + 1'b1;
		end
	end
	assign tk.tick = tk.run && ((cnt_reg & mask) == mask);
endmodule

// ---- core/adcs_mux.sv ----
// analog switch decode: input source, channel and reference selects
// assumes the analog core reads these as static switch controls
`timescale 1ns/1ps
`include "adcs_params.svh"
module adcs_mux (
	input wire logic [2:0] src_sel,
	input wire logic [3:0] chan_sel,
	input wire logic [1:0] ref_sel,
	output logic [7:0] chan_on,
	output logic bandgap_on,
	output logic ground_on,
	output logic ref_supply_on,
	output logic ref_pin_on
);
	import adcs_pkg::*;
	adcs_src_t src;
	always_comb begin
		if (src_sel == `ADCS_SRC_BANDGAP) begin
			src = ADCS_SRC_BG;
		end else if (src_sel >= `ADCS_SRC_GND_LO &&
			src_sel <= `ADCS_SRC_GND_HI) begin
			src = ADCS_SRC_GND;
		end else begin
			src = ADCS_SRC_EXT;
		end
	end
	always_comb begin
		chan_on = '0;
		// internal source opens every external switch
		if (src == ADCS_SRC_EXT && !chan_sel[3]) begin
			chan_on[chan_sel[2:0]] = 1'b1;
		end
	end
	assign bandgap_on = (src == ADCS_SRC_BG);
	assign ground_on = (src == ADCS_SRC_GND);
	assign ref_supply_on = (ref_sel == `ADCS_REF_SUPPLY);
	assign ref_pin_on = !ref_supply_on;
endmodule

// ---- core/adcs_top.sv ----
// control sequencer for a single 12-bit successive-approximation converter
// assumes a register master with one-cycle strobes and an analog core
// that shifts result bits after each conversion clock tick
//
// Design decisions made here: the register addresses and the strobed register port.
`timescale 1ns/1ps
`include "adcs_params.svh"
module adcs_top (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [1:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic [11:0] core_result,
	input wire logic [7:0] pin_adc_sel,
	output logic core_power_on,
	output logic core_sample,
	output logic core_conv_tick,
	output logic [7:0] chan_on,
	output logic bandgap_on,
	output logic ground_on,
	output logic ref_supply_on,
	output logic ref_pin_on,
	output logic [7:0] pin_digital_off,
	output logic [7:0] pin_pullup_off,
	output logic conv_irq_flag,
	output logic conv_irq
);
	import adcs_pkg::*;
	// =========================================================
	// reset release
	logic rst_meta_reg;
	logic rst_sync_b;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_meta_reg <= 1'b0;
			rst_sync_b <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_sync_b <= rst_meta_reg;
		end
	end
	// =========================================================
	// registers
	logic [7:0] ctrl_reg;
	logic [7:0] sel_reg;
	logic [7:0] res_high_reg;
	logic [7:0] res_low_reg;
	logic busy_reg;
	logic irq_flag_reg;
	adcs_state_t state_reg;
	logic [4:0] period_reg;
	logic start_fall;
	logic done;
	logic wr_ctrl;
	assign wr_ctrl = reg_wr && reg_addr == `ADCS_ADDR_CTRL;
	// fall of the start bit, seen only on a write that clears it
	assign start_fall = wr_ctrl && ctrl_reg[`ADCS_BIT_START] &&
		!reg_wdata[`ADCS_BIT_START];
	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			ctrl_reg <= `ADCS_CTRL_RESET;
		end else if (wr_ctrl) begin
			ctrl_reg <= reg_wdata; // busy bit image ignored on read
		end
	end
	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			sel_reg <= `ADCS_SEL_RESET;
		end else if (reg_wr && reg_addr == `ADCS_ADDR_SEL) begin
			sel_reg <= reg_wdata;
		end
	end
	logic enable;
	assign enable = ctrl_reg[`ADCS_BIT_EN];
	assign core_power_on = enable;
	// =========================================================
	// conversion clock
	adcs_tick_if tk ();
	assign tk.divider = sel_reg[2:0];
	assign tk.run = busy_reg;
	adcs_clkdiv #(.DIV_W(7)) u_div (
		.clk(clk),
		.rst_sync_b(rst_sync_b),
		.tk(tk)
	);
	// =========================================================
	// sequencer
	// gated by enable: an abort in the last period must raise no request
	assign done = enable && state_reg == ADCS_CONVERT && tk.tick &&
		period_reg == `ADCS_TOTAL_PERIODS - 5'h01;
	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			state_reg <= ADCS_IDLE;
			period_reg <= '0;
		end else if (!enable) begin
			state_reg <= ADCS_IDLE;
			period_reg <= '0;
		end else begin
			unique case (state_reg)
				ADCS_IDLE: begin
					// a start while busy never reaches here
					if (start_fall) begin
						state_reg <= ADCS_SAMPLE;
						period_reg <= '0;
					end
				end
				ADCS_SAMPLE: begin
					if (tk.tick) begin
						period_reg <= period_reg + 5'h01;
						if (period_reg == `ADCS_SAMPLE_PERIODS - 5'h01) begin
							state_reg <= ADCS_CONVERT;
						end
					end
				end
				ADCS_CONVERT: begin
					if (tk.tick) begin
						period_reg <= period_reg + 5'h01;
						if (done) begin
							state_reg <= ADCS_IDLE;
							period_reg <= '0;
						end
					end
				end
			endcase
		end
	end
	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			busy_reg <= 1'b0;
		end else if (!enable || done) begin
			busy_reg <= 1'b0;
		end else if (start_fall) begin
			busy_reg <= 1'b1;
		end
	end
	assign core_sample = state_reg == ADCS_SAMPLE;
	assign core_conv_tick = state_reg == ADCS_CONVERT && tk.tick;
	// =========================================================
	// result capture, loaded with the busy clear
	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			res_high_reg <= 8'h00;
			res_low_reg <= 8'h00;
		end else if (done && enable) begin
			if (ctrl_reg[`ADCS_BIT_ALIGN]) begin
				res_high_reg <= {4'h0, core_result[11:8]};
				res_low_reg <= core_result[7:0];
			end else begin
				res_high_reg <= core_result[11:4];
				res_low_reg <= {core_result[3:0], 4'h0};
			end
		end
	end
	// flag cleared by writing 0 to bit 0 of the select-free slot? no:
	// the controller owns clearing; here it clears on a read of the high result byte
	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			irq_flag_reg <= 1'b0;
		end else if (done) begin
			irq_flag_reg <= 1'b1;
		end else if (reg_rd && reg_addr == `ADCS_ADDR_RES_HIGH) begin
			irq_flag_reg <= 1'b0;
		end
	end
	logic irq_reg;
	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			irq_reg <= 1'b0;
		end else begin
			irq_reg <= done;
		end
	end
	assign conv_irq = irq_reg;
	assign conv_irq_flag = irq_flag_reg;
	// =========================================================
	// analog switches and pins
	adcs_mux u_mux (
		.src_sel(sel_reg[7:5]),
		.chan_sel(ctrl_reg[3:0]),
		.ref_sel(sel_reg[4:3]),
		.chan_on(chan_on),
		.bandgap_on(bandgap_on),
		.ground_on(ground_on),
		.ref_supply_on(ref_supply_on),
		.ref_pin_on(ref_pin_on)
	);
	assign pin_digital_off = pin_adc_sel;
	assign pin_pullup_off = pin_adc_sel;
	// =========================================================
	// read port
	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			unique case (reg_addr)
				`ADCS_ADDR_RES_HIGH: reg_rdata <= res_high_reg;
				`ADCS_ADDR_RES_LOW: reg_rdata <= res_low_reg;
				`ADCS_ADDR_CTRL: reg_rdata <= {ctrl_reg[7], busy_reg,
					ctrl_reg[5:0]};
				`ADCS_ADDR_SEL: reg_rdata <= sel_reg;
			endcase
		end else begin
			reg_rdata <= 8'h00;
		end
	end
	// =========================================================
	// checks
	sequence s_started;
		start_fall && state_reg == ADCS_IDLE && enable;
	endsequence
	AST_BUSY_SET: assert property (@(posedge clk)
		disable iff (!rst_sync_b)
		s_started |=> busy_reg) else $error("busy not set");
	AST_DONE_CLR: assert property (@(posedge clk)
		disable iff (!rst_sync_b)
		done |=> !busy_reg && irq_flag_reg) else $error("no finish");
	AST_IRQ: assert property (@(posedge clk)
		disable iff (!rst_sync_b)
		done |=> conv_irq ##1 !conv_irq) else $error("irq pulse");
	AST_HOLD: assert property (@(posedge clk)
		disable iff (!rst_sync_b)
		!enable |=> $stable(res_high_reg) && $stable(res_low_reg))
		else $error("result changed while off");
	AST_ALIGN0: assert property (@(posedge clk)
		disable iff (!rst_sync_b)
		done && !ctrl_reg[`ADCS_BIT_ALIGN] |=>
		res_high_reg == $past(core_result[11:4]) &&
		res_low_reg[7:4] == $past(core_result[3:0]) &&
		res_low_reg[3:0] == 4'h0) else $error("align 0");
	AST_ALIGN1: assert property (@(posedge clk)
		disable iff (!rst_sync_b)
		done && ctrl_reg[`ADCS_BIT_ALIGN] |=>
		res_low_reg == $past(core_result[7:0]) &&
		res_high_reg[3:0] == $past(core_result[11:8]) &&
		res_high_reg[7:4] == 4'h0) else $error("align 1");
	// a tick in the same cycle may advance the count legitimately
	AST_NO_RESTART: assert property (@(posedge clk)
		disable iff (!rst_sync_b)
		busy_reg && start_fall && state_reg != ADCS_IDLE && !tk.tick |=>
		$stable(state_reg) && $stable(period_reg))
		else $error("restart");
	AST_EXT_OFF: assert property (@(posedge clk)
		disable iff (!rst_sync_b)
		(bandgap_on || ground_on) |-> chan_on == 8'h00)
		else $error("external left on");
	AST_REF: assert property (@(posedge clk)
		disable iff (!rst_sync_b)
		ref_supply_on |-> !ref_pin_on && sel_reg[4:3] == 2'h1)
		else $error("reference");
endmodule

// ---- test/adcs_core_model.sv ----
// behavioural analog core facing the converter control sequencer
// assumes the sequencer drives power and sample controls on clk
`timescale 1ns/1ps
module adcs_core_model (
	input wire logic clk,
	input wire logic core_power_on,
	input wire logic core_sample,
	input wire logic [11:0] level,
	output logic [11:0] core_result
);
	logic [11:0] held;
	initial held = 12'h000;
	// ==========
	// sample and hold
	// frozen once sampling ends, so a late input change cannot leak in
	always @(posedge clk) begin
		if (core_power_on && core_sample) begin
			held <= level;
		end
	end
	// powered down gives no valid result: show the inverse instead
	assign core_result = core_power_on ? held : ~held;
endmodule

// ---- test/adc_control_sequencer_tb.sv ----
// self-checking bench for the converter control sequencer
// assumes adcs_top, its package, interface and analog core model
`timescale 1ns/1ps
`include "adcs_params.svh"
module adc_control_sequencer_tb;
	logic clk, rst_b, reg_wr, reg_rd, core_power_on, core_sample;
	logic core_conv_tick, bandgap_on, ground_on, ref_supply_on;
	logic ref_pin_on, conv_irq_flag, conv_irq;
	logic [1:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, pin_adc_sel, chan_on;
	logic [7:0] pin_digital_off, pin_pullup_off, rd, ctl;
	logic [11:0] level, core_result;
	int err_total, comparisons, cycles, t0, n, code, hi, lo, src, ch, rf;
	int tick_seen, sample_seen;
	adcs_top dut_u (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .core_result(core_result),
		.pin_adc_sel(pin_adc_sel), .core_power_on(core_power_on),
		.core_sample(core_sample), .core_conv_tick(core_conv_tick),
		.chan_on(chan_on), .bandgap_on(bandgap_on), .ground_on(ground_on),
		.ref_supply_on(ref_supply_on), .ref_pin_on(ref_pin_on),
		.pin_digital_off(pin_digital_off), .pin_pullup_off(pin_pullup_off),
		.conv_irq_flag(conv_irq_flag), .conv_irq(conv_irq));
	adcs_core_model model_u (.clk(clk), .core_power_on(core_power_on),
		.core_sample(core_sample), .level(level),
		.core_result(core_result));
	// ==========
	// clock and hang guard
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// counted on the falling edge, where the strobes have settled
	always @(negedge clk) begin
		tick_seen += (core_conv_tick === 1'b1);
		sample_seen += (core_sample === 1'b1);
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			err_total++;
			results();
		end
	end
	// ==========
	// shared tasks
	task chk(input string nm, input logic [11:0] e, input logic [11:0] s);
		comparisons++;
		if (s !== e) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", nm, e, s);
		end
	endtask
	task wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
		#1;
	endtask
	// read data stand only in the cycle after the strobe
	task rdr(input logic [1:0] a, output logic [7:0] d);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	task results;
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// ==========
	// main sequence
	initial begin
		rst_b = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 2'h0;
		reg_wdata = 8'h00;
		pin_adc_sel = 8'h00;
		level = 12'h000;
		err_total = 0;
		comparisons = 0;
		cycles = 0;
		void'($urandom(32'h1d761f36));
		repeat (20) @(posedge clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge clk);
		rdr(`ADCS_ADDR_CTRL, rd);
		chk("ctrl_reset", 12'(`ADCS_CTRL_RESET), 12'(rd));
		rdr(`ADCS_ADDR_SEL, rd);
		chk("sel_reset", 12'(`ADCS_SEL_RESET), 12'(rd));
		chk("ref_pin_reset", 12'h001, 12'(ref_pin_on));
		wr(`ADCS_ADDR_CTRL, 8'h7f);
		rdr(`ADCS_ADDR_CTRL, rd);
		chk("busy_readonly", 12'h03f, 12'(rd));
		$display("test reset and access done");
		// ==========
		// switch decode, every source, channel and reference code
		for (int i = 0; i < 32; i++) begin
			src = i % 8;
			ch = i / 2;
			rf = i % 4;
			pin_adc_sel <= 8'($urandom);
			wr(`ADCS_ADDR_SEL, 8'((src << 5) | (rf << 3) | 1));
			wr(`ADCS_ADDR_CTRL, 8'(ch));
			n = ((src == 0 || src > 4) && ch < 8) ? (1 << ch) : 0;
			chk("chan_on", 12'(n), 12'(chan_on));
			chk("bandgap_on", 12'(src == 1), 12'(bandgap_on));
			chk("ground_on", 12'(src > 1 && src < 5), 12'(ground_on));
			chk("ref_supply", 12'(rf == 1), 12'(ref_supply_on));
			chk("ref_pin", 12'(rf != 1), 12'(ref_pin_on));
			chk("pin_digital", 12'(pin_adc_sel), 12'(pin_digital_off));
			chk("pin_pullup", 12'(pin_adc_sel), 12'(pin_pullup_off));
		end
		$display("test switch decode done");
		// ==========
		// conversions at both alignments and several dividers
		for (int i = 0; i < 4; i++) begin
			code = 2 * i + 1;
			level = 12'($urandom);
			ctl = {3'b001, i[0], 4'h0};
			wr(`ADCS_ADDR_SEL, 8'(code));
			wr(`ADCS_ADDR_CTRL, ctl);
			repeat (4) @(posedge clk);
			tick_seen = 0;
			sample_seen = 0;
			wr(`ADCS_ADDR_CTRL, ctl | 8'h80);
			wr(`ADCS_ADDR_CTRL, ctl);
			t0 = cycles;
			rdr(`ADCS_ADDR_CTRL, rd);
			chk("busy_set", 12'(ctl | 8'h40), 12'(rd));
			// a second pulse mid-conversion must not restart the count
			wr(`ADCS_ADDR_CTRL, ctl | 8'h80);
			wr(`ADCS_ADDR_CTRL, ctl);
			do begin
				@(posedge clk);
				#1;
			end while (conv_irq !== 1'b1 && cycles - t0 < 3000);
			n = cycles - t0;
			chk("conv_time", 12'h001,
				12'(n >= (16 << code) - 1 && n <= (16 << code) + 4));
			chk("sample_cycles", 12'(4 << code), 12'(sample_seen));
			chk("conv_ticks", 12'h00c, 12'(tick_seen));
			chk("irq_flag", 12'h001, 12'(conv_irq_flag));
			@(posedge clk);
			#1;
			chk("irq_pulse", 12'h000, 12'(conv_irq));
			hi = i[0] ? level >> 8 : level >> 4;
			lo = i[0] ? level & 255 : (level & 15) << 4;
			rdr(`ADCS_ADDR_RES_HIGH, rd);
			chk("result_high", 12'(hi), 12'(rd));
			rdr(`ADCS_ADDR_RES_LOW, rd);
			chk("result_low", 12'(lo), 12'(rd));
			chk("irq_cleared", 12'h000, 12'(conv_irq_flag));
			rdr(`ADCS_ADDR_CTRL, rd);
			chk("busy_clear", 12'(ctl), 12'(rd));
		end
		$display("test conversions done");
		// ==========
		// abort by disabling, results must hold and no request follows
		level = ~level;
		wr(`ADCS_ADDR_CTRL, 8'ha0);
		wr(`ADCS_ADDR_CTRL, 8'h20);
		repeat (5) @(posedge clk);
		wr(`ADCS_ADDR_CTRL, 8'h00);
		chk("power_off", 12'h000, 12'(core_power_on));
		n = 0;
		repeat (300) begin
			@(posedge clk);
			#1;
			n += (conv_irq === 1'b1);
		end
		chk("abort_irq", 12'h000, 12'(n));
		wr(`ADCS_ADDR_RES_HIGH, 8'h5a);
		rdr(`ADCS_ADDR_RES_HIGH, rd);
		chk("hold_high", 12'(hi), 12'(rd));
		rdr(`ADCS_ADDR_RES_LOW, rd);
		chk("hold_low", 12'(lo), 12'(rd));
		$display("test disable abort done");
		results();
	end
endmodule
